// [hdl/cft_top.sv]
// What this block does
// - On-state fault is blanked 6, 12, 24 or 48 us after gate turns on.
// - Off-state fault is blanked 55, 81, 162 or 325 us after gate turns off.
// - On-state fault condition must persist 3.0 us before it counts.
// - Faulted auto-retry channels are driven again every 8 ms retry period.
// - Enable inactive turns gates and diagnostics off and resets the retry timer.
// - Master reset low stops the timer clock, gates, serial side and fault flag.
//
// The AHB-Lite register port and the register offsets were left to the implementer.
module cft_top #(
    parameter int NCH         = 6,
    parameter int RETRY_TICKS = cft_pkg::RETRY_TICKS
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Device pins
    input  wire logic              master_reset_n,
    input  wire logic              global_enable_n,
    input  wire logic              chip_select_n,
    input  wire logic [NCH-1:0]    parallel_gate_inputs,
    input  wire logic [NCH-1:0]    drain_feedback_inputs,
    output logic [NCH-1:0]         gate_drive_outputs,
    // Open-drain fault flag
    input  wire logic              fault_flag_n_sense,
    output logic                   fault_flag_n_level,
    output logic                   fault_flag_n_oe_n,
    // Interrupt
    output logic                   irq
);

    logic                        rst;
    logic                        run;
    logic [2:0]                  div_q;
    logic                        tick;
    cft_pkg::cft_ctrl_t          ctrl_q;
    logic [cft_pkg::STAT_W-1:0]  stat_q;
    logic [cft_pkg::STAT_W-1:0]  mask_q;
    logic [cft_pkg::STAT_W-1:0]  events;
    logic                        acc;
    logic                        wr_q;
    logic [7:0]                  addr_q;
    logic [31:0]                 rdata_q;
    logic                        rd_stat;
    logic [NCH-1:0]              clr_q;
    logic [NCH-1:0]              fault;
    logic [NCH-1:0]              fault_set;
    logic [NCH-1:0]              retry;
    logic [cft_pkg::CNT_W-1:0]   retry_q;
    logic                        retry_hit;
    logic                        cs_prev_q;
    logic [7:0]                  gap_q;
    logic                        framed_q;
    logic                        gap_err;
    logic                        flag_oe_n_q;

    // Master reset acts like a system reset for all timing state
    assign rst = sys_rst | ~master_reset_n;
    assign run = ~global_enable_n;

    // Timer clock tick, frozen while in reset
    always_ff @(posedge clock)
    begin
        if (rst)
            div_q <= '0;
        else if (div_q == 3'(cft_pkg::TIMER_DIV - 1))
            div_q <= '0;
        else
            div_q <= div_q + 3'h1;
    end

    assign tick = ~rst & (div_q == 3'(cft_pkg::TIMER_DIV - 1));

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign acc       = hsel & htrans[1] & hready;
    assign rd_stat   = acc & ~hwrite & (haddr[7:0] == cft_pkg::STATUS_OFS) & (haddr[31:8] == '0);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wr_q   <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wr_q   <= acc & hwrite & (haddr[31:8] == '0);
            addr_q <= haddr[7:0];
        end
    end

    // Read data captured in the address phase so it stands for the whole data phase
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            rdata_q <= 32'h0000_0000;
        else if (acc && !hwrite && haddr[31:8] == '0)
        begin
            case (haddr[7:0])
                cft_pkg::CTRL_OFS:   rdata_q <= 32'(ctrl_q);
                cft_pkg::STATUS_OFS: rdata_q <= 32'(stat_q);
                cft_pkg::MASK_OFS:   rdata_q <= 32'(mask_q);
                cft_pkg::FAULT_OFS:  rdata_q <= 32'(fault);
                cft_pkg::PINS_OFS:   rdata_q <= {16'h0000, fault_flag_n_sense, chip_select_n,
                                                 global_enable_n, master_reset_n,
                                                 6'(drain_feedback_inputs),
                                                 6'(gate_drive_outputs)};
                default:             rdata_q <= 32'h0000_0000;
            endcase
        end
        else if (acc)
            rdata_q <= 32'h0000_0000;
    end

    assign hrdata = rdata_q;

    // Registers lose their programming under master reset as well
    always_ff @(posedge clock)
    begin
        if (rst)
            ctrl_q <= cft_pkg::CTRL_RST;
        else if (wr_q && addr_q == cft_pkg::CTRL_OFS)
            ctrl_q <= cft_pkg::cft_ctrl_t'(hwdata[$bits(cft_pkg::cft_ctrl_t)-1:0]);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            mask_q <= '0;
        else if (wr_q && addr_q == cft_pkg::MASK_OFS)
            mask_q <= hwdata[cft_pkg::STAT_W-1:0];
    end

    // Write one to a fault bit releases a latched-off channel
    always_ff @(posedge clock)
    begin
        if (rst)
            clr_q <= '0;
        else if (wr_q && addr_q == cft_pkg::FAULT_OFS)
            clr_q <= hwdata[NCH-1:0];
        else
            clr_q <= '0;
    end

    // Sticky events, cleared by a read; a new event in that cycle survives
    assign events = {gap_err, 6'(fault_set)};

    always_ff @(posedge clock)
    begin
        if (rst)
            stat_q <= '0;
        else
            stat_q <= (stat_q & ~{cft_pkg::STAT_W{rd_stat}}) | events;
    end

    assign irq = |(stat_q & mask_q);

    // Global retry timer, held at zero while disabled or nothing to retry
    always_ff @(posedge clock)
    begin
        if (rst || !run || !(|(fault & ctrl_q.recovery_mode_bits[NCH-1:0])))
            retry_q <= '0;
        else if (tick)
            retry_q <= retry_hit ? '0 : retry_q + 1'b1;
    end

    assign retry_hit = tick & (retry_q == cft_pkg::CNT_W'(RETRY_TICKS - 1));
    assign retry     = {NCH{retry_hit}} & ctrl_q.recovery_mode_bits[NCH-1:0];

    generate
        for (genvar i = 0; i < NCH; i++)
        begin : g_ch
            cft_chan i_cft_chan (
                .clock      (clock),
                .rst        (rst),
                .tick       (tick),
                .run        (run),
                .on_ticks   (cft_pkg::on_blank_ticks(ctrl_q.on_blank_select)),
                .off_ticks  (cft_pkg::off_blank_ticks(ctrl_q.off_blank_select)),
                .gate_in    (parallel_gate_inputs[i]),
                .drain_high (drain_feedback_inputs[i]),
                .retry      (retry[i]),
                .clear      (clr_q[i]),
                .gate_out   (gate_drive_outputs[i]),
                .fault      (fault[i]),
                .fault_set  (fault_set[i])
            );
        end
    endgenerate

    // Frame gap check: a short gap is only reported, the frame is not refused
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cs_prev_q <= 1'b1;
            framed_q  <= 1'b0;
            gap_q     <= '0;
        end
        else
        begin
            cs_prev_q <= chip_select_n;
            if (!chip_select_n)
            begin
                framed_q <= 1'b1;
                gap_q    <= '0;
            end
            else if (gap_q != 8'(cft_pkg::CS_GAP_CYCLES))
                gap_q <= gap_q + 8'h01;
        end
    end

    assign gap_err = cs_prev_q & ~chip_select_n & framed_q
                     & (gap_q < 8'(cft_pkg::CS_GAP_CYCLES));

    // Flag pulls low on a latched fault, released during reset, disable and open frames
    always_ff @(posedge clock)
    begin
        if (rst)
            flag_oe_n_q <= 1'b1;
        else
            flag_oe_n_q <= ~(run & chip_select_n & (|fault));
    end

    assign fault_flag_n_level = 1'b0;
    assign fault_flag_n_oe_n = flag_oe_n_q;

endmodule // cft_top

// [pkg/cft_pkg.sv]
package cft_pkg;

    // Clocking
    localparam int CLK_KHZ       = 20000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIMER_CLK_KHZ = 4000;
    localparam int TIMER_DIV     = CLK_KHZ / TIMER_CLK_KHZ;
    localparam int TICK_NS       = 1000000 / TIMER_CLK_KHZ;
    localparam int CNT_W         = 16;

    // Blanking times per select code, in ns
    localparam int ON_BLANK_00_NS  = 6000;
    localparam int ON_BLANK_01_NS  = 12000;
    localparam int ON_BLANK_10_NS  = 24000;
    localparam int ON_BLANK_11_NS  = 48000;
    localparam int OFF_BLANK_00_NS = 55000;
    localparam int OFF_BLANK_01_NS = 81000;
    localparam int OFF_BLANK_10_NS = 162000;
    localparam int OFF_BLANK_11_NS = 325000;

    // Filter, retry and frame gap
    localparam int FILTER_NS      = 3000;
    localparam int FILTER_TICKS   = FILTER_NS / TICK_NS;
    localparam int RETRY_MS       = 8;
    localparam int RETRY_TICKS    = RETRY_MS * 1000000 / TICK_NS;
    localparam int CS_GAP_NS      = 1600;
    localparam int CS_GAP_CYCLES  = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] MASK_OFS   = 8'h08;
    localparam logic [7:0] FAULT_OFS  = 8'h0c;
    localparam logic [7:0] PINS_OFS   = 8'h10;

    // Status layout: bits 5:0 channel faults, bit 6 frame gap violation
    localparam int STAT_W       = 7;
    localparam int STAT_GAP_BIT = 6;

    typedef struct packed {
        logic [5:0] recovery_mode_bits;
        logic [1:0] off_blank_select;
        logic [1:0] on_blank_select;
    } cft_ctrl_t;

    localparam cft_ctrl_t CTRL_RST = '{recovery_mode_bits: 6'h00,
                                       off_blank_select:   2'h2,
                                       on_blank_select:    2'h2};

    function automatic logic [CNT_W-1:0] on_blank_ticks(input logic [1:0] sel);
        case (sel)
            2'h0:    on_blank_ticks = CNT_W'(ON_BLANK_00_NS / TICK_NS);
            2'h1:    on_blank_ticks = CNT_W'(ON_BLANK_01_NS / TICK_NS);
            2'h2:    on_blank_ticks = CNT_W'(ON_BLANK_10_NS / TICK_NS);
            default: on_blank_ticks = CNT_W'(ON_BLANK_11_NS / TICK_NS);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] off_blank_ticks(input logic [1:0] sel);
        case (sel)
            2'h0:    off_blank_ticks = CNT_W'(OFF_BLANK_00_NS / TICK_NS);
            2'h1:    off_blank_ticks = CNT_W'(OFF_BLANK_01_NS / TICK_NS);
            2'h2:    off_blank_ticks = CNT_W'(OFF_BLANK_10_NS / TICK_NS);
            default: off_blank_ticks = CNT_W'(OFF_BLANK_11_NS / TICK_NS);
        endcase
    endfunction

endpackage

// [hdl/cft_chan.sv]
module cft_chan (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    // Timing
    input  wire logic                    tick,
    input  wire logic                    run,
    input  wire logic [cft_pkg::CNT_W-1:0] on_ticks,
    input  wire logic [cft_pkg::CNT_W-1:0] off_ticks,
    // Channel pins
    input  wire logic                    gate_in,
    input  wire logic                    drain_high,
    // Fault control
    input  wire logic                    retry,
    input  wire logic                    clear,
    output logic                         gate_out,
    output logic                         fault,
    output logic                         fault_set
);

    logic                      drive;
    logic                      prev_q;
    logic [cft_pkg::CNT_W-1:0] blank_q;
    logic [cft_pkg::CNT_W-1:0] filt_q;
    logic                      fault_q;
    logic                      gate_q;
    logic                      on_hit;
    logic                      off_hit;

    // A fault or disable is treated as an edge, so the retry restarts on-blanking
    assign drive = run & gate_in & ~fault_q;

    always_ff @(posedge clock)
    begin
        if (rst)
            prev_q <= 1'b0;
        else
            prev_q <= drive;
    end

    always_ff @(posedge clock)
    begin
        if (rst || !run)
            blank_q <= '0;
        else if (drive != prev_q)
            blank_q <= drive ? on_ticks : off_ticks;
        else if (tick && blank_q != '0)
            blank_q <= blank_q - 1'b1;
    end

    // Condition must hold without a break for the whole filter time
    always_ff @(posedge clock)
    begin
        if (rst || !run || !prev_q || !drain_high || blank_q != '0)
            filt_q <= '0;
        else if (tick && filt_q != cft_pkg::CNT_W'(cft_pkg::FILTER_TICKS))
            filt_q <= filt_q + 1'b1;
    end

    assign on_hit  = prev_q & drive & (filt_q == cft_pkg::CNT_W'(cft_pkg::FILTER_TICKS));
    assign off_hit = run & ~prev_q & ~drive & ~fault_q & ~gate_in & ~drain_high
                     & (blank_q == '0);
    assign fault_set = (on_hit | off_hit) & ~fault_q;

    // Set wins over clear and retry
    always_ff @(posedge clock)
    begin
        if (rst)
            fault_q <= 1'b0;
        else if (fault_set)
            fault_q <= 1'b1;
        else if (clear || retry)
            fault_q <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            gate_q <= 1'b0;
        else
            gate_q <= drive & ~fault_set;
    end

    assign gate_out = gate_q;
    assign fault    = fault_q;

endmodule // cft_chan

// [dv/cft_drain_model.sv]
module cft_drain_model #(
    parameter int NCH = 6
) (
    // Gate side
    input  wire logic [NCH-1:0] gate_drive_outputs,
    // Fault injection
    input  wire logic [NCH-1:0] load_short,
    input  wire logic [NCH-1:0] gnd_short,
    // Drain comparators
    output logic      [NCH-1:0] drain_feedback_inputs
);
    timeunit 1ns;
    timeprecision 1ps;

    // Healthy switch pulls its drain low only while on; a ground short wins over all
    assign drain_feedback_inputs = (~gate_drive_outputs | load_short) & ~gnd_short;
endmodule // cft_drain_model

// [dv/cft_checker.sv]
module cft_checker #(
    parameter int NCH = 6
) (
    // Clock and reset
    input wire logic           clock,
    input wire logic           sys_rst,
    // Bus
    input wire logic           hsel,
    input wire logic [1:0]     htrans,
    input wire logic           hready,
    input wire logic           hreadyout,
    input wire logic           hresp,
    input wire logic [31:0]    hrdata,
    // Pins
    input wire logic           master_reset_n,
    input wire logic           global_enable_n,
    input wire logic           chip_select_n,
    input wire logic [NCH-1:0] parallel_gate_inputs,
    input wire logic [NCH-1:0] gate_drive_outputs,
    input wire logic           fault_flag_n_oe_n,
    input wire logic           irq
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    chk_hrdata_hold: assert property (!$past(hsel && htrans[1] && hready) |-> $stable(hrdata))
        else $error("read data moved without a transfer");
    chk_gate_cmd: assert property ((gate_drive_outputs & ~$past(parallel_gate_inputs)) == '0)
        else $error("gate driven without command");
    chk_enable_off: assert property (global_enable_n |=> gate_drive_outputs == '0)
        else $error("gate on while disabled");
    chk_flag_cause: assert property ($fell(fault_flag_n_oe_n) |->
        $past(chip_select_n) && !$past(global_enable_n))
        else $error("flag pulled while disabled or selected");
    chk_reset_off: assert property (!master_reset_n |=>
        gate_drive_outputs == '0 && fault_flag_n_oe_n && !irq)
        else $error("outputs active in master reset");
    chk_irq_reset: assert property ($rose(master_reset_n) |-> !irq)
        else $error("interrupt set after master reset");
    chk_on_blank: assert property ($rose(parallel_gate_inputs[0]) && !global_enable_n
        && fault_flag_n_oe_n |=> fault_flag_n_oe_n [*8])
        else $error("fault flagged inside on blanking");

    cover property ($fell(fault_flag_n_oe_n));
    cover property ($rose(irq));
    cover property ($rose(global_enable_n));
endmodule // cft_checker

bind cft_top cft_checker #(.NCH(NCH)) i_cft_checker (
    .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .master_reset_n(master_reset_n),
    .global_enable_n(global_enable_n), .chip_select_n(chip_select_n),
    .parallel_gate_inputs(parallel_gate_inputs), .gate_drive_outputs(gate_drive_outputs),
    .fault_flag_n_oe_n(fault_flag_n_oe_n), .irq(irq)
);

// [dv/channel_fault_timing_bench.sv]
module channel_fault_timing_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // Short retry period keeps the run brief
    localparam int RT = 20;
    localparam int ON_NS [4] = '{6000, 12000, 24000, 48000};
    localparam int OFF_NS [4] = '{55000, 81000, 162000, 325000};

    logic        clock;
    logic        sys_rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        master_reset_n;
    logic        global_enable_n;
    logic        chip_select_n;
    logic [5:0]  gate_in;
    logic [5:0]  drain;
    logic [5:0]  gate_out;
    logic [5:0]  load_short;
    logic [5:0]  gnd_short;
    logic        flag_o;
    logic        flag_oe_n;
    logic        flag_wire;
    logic        irq;
    logic [31:0] rd;
    int          fails;
    int          n_compared;
    int          cyc;
    int          n;

    // Open-drain flag with pull-up
    assign flag_wire = flag_oe_n ? 1'b1 : flag_o;

    cft_top #(.NCH(6), .RETRY_TICKS(RT)) i_cft_top (
        .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .master_reset_n(master_reset_n), .global_enable_n(global_enable_n),
        .chip_select_n(chip_select_n), .parallel_gate_inputs(gate_in),
        .drain_feedback_inputs(drain), .gate_drive_outputs(gate_out),
        .fault_flag_n_sense(flag_wire), .fault_flag_n_level(flag_o),
        .fault_flag_n_oe_n(flag_oe_n),
        .irq(irq)
    );

    cft_drain_model #(.NCH(6)) i_cft_drain_model (
        .gate_drive_outputs(gate_out), .load_short(load_short), .gnd_short(gnd_short),
        .drain_feedback_inputs(drain)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic tk(input int c);
        repeat (c) @(posedge clock);
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= a;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkw(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("[FAIL] %0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wait_flag();
        n = 0;
        while (flag_oe_n !== 1'b0 && n < 8000)
        begin
            tk(1);
            n++;
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fails++;
            finish_test();
        end
    end

    initial
    begin
        {sys_rst, master_reset_n, chip_select_n} = 3'h7;
        {hsel, htrans, hwrite, haddr, hwdata} = '0;
        {global_enable_n, gate_in, load_short, gnd_short} = '0;
        tk(8);
        sys_rst <= 1'b0;
        tk(1);
        rdchk(32'h00, 32'ha);
        rdchk(32'h08, 32'h0);
        rdchk(32'h100, 32'h0);
        rdchk(32'h10, 32'hdfc0);
        $display("reset values done");
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, 32'h00, 32'h8 | s);
            load_short[0] <= 1'b1;
            gate_in[0]    <= 1'b1;
            wait_flag();
            chkw(n, (ON_NS[s] / 250 + 12) * 5 - 10, (ON_NS[s] / 250 + 12) * 5 + 12);
            rdchk(32'h10, 32'h5fc0);
            gate_in[0]    <= 1'b0;
            load_short[0] <= 1'b0;
            bus(1'b1, 32'h0c, 32'h1);
            rdchk(32'h04, 32'h1);
            chk(irq, 1'b0);
        end
        $display("on blanking done");
        // Short glitch below the filter must be ignored
        bus(1'b1, 32'h00, 32'h8);
        gate_in[0] <= 1'b1;
        tk(200);
        load_short[0] <= 1'b1;
        tk(50);
        load_short[0] <= 1'b0;
        tk(100);
        rdchk(32'h04, 32'h0);
        load_short[0] <= 1'b1;
        wait_flag();
        chkw(n, 52, 72);
        {gate_in[0], load_short[0]} <= 2'h0;
        bus(1'b1, 32'h0c, 32'h1);
        rdchk(32'h04, 32'h1);
        $display("filter done");
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, 32'h00, 32'h2 | (s << 2));
            gate_in[1] <= 1'b1;
            tk(10);
            gnd_short[1] <= 1'b1;
            gate_in[1]   <= 1'b0;
            wait_flag();
            chkw(n, OFF_NS[s] / 50 - 10, OFF_NS[s] / 50 + 12);
            gnd_short[1] <= 1'b0;
            bus(1'b1, 32'h0c, 32'h2);
            rdchk(32'h04, 32'h2);
        end
        $display("off blanking done");
        bus(1'b1, 32'h08, 32'h1);
        bus(1'b1, 32'h00, 32'h1a);
        load_short[0] <= 1'b1;
        gate_in[0]    <= 1'b1;
        wait_flag();
        global_enable_n <= 1'b1;
        tk(2);
        chk(irq, 1'b1);
        tk(300);
        chk(gate_out, 6'h0);
        rdchk(32'h0c, 32'h1);
        global_enable_n <= 1'b0;
        n = 0;
        while (gate_out[0] !== 1'b1 && n < 400)
        begin
            tk(1);
            n++;
        end
        chkw(n, 1, RT * 5 + 12);
        rdchk(32'h04, 32'h1);
        tk(1);
        chk(irq, 1'b0);
        {gate_in[0], load_short[0]} <= 2'h0;
        bus(1'b1, 32'h0c, 32'h1);
        $display("retry and interrupt done");
        for (int g = 0; g < 2; g++)
        begin
            tk(40);
            chip_select_n <= 1'b0;
            tk(5);
            chip_select_n <= 1'b1;
            tk(g ? 40 : 10);
            chip_select_n <= 1'b0;
            tk(5);
            chip_select_n <= 1'b1;
            tk(2);
            rdchk(32'h04, g ? 32'h0 : 32'h40);
        end
        $display("frame gap done");
        bus(1'b1, 32'h00, 32'h3ff);
        rdchk(32'h00, 32'h3ff);
        master_reset_n <= 1'b0;
        tk(2);
        master_reset_n <= 1'b1;
        tk(1);
        rdchk(32'h00, 32'ha);
        rdchk(32'h08, 32'h0);
        $display("master reset done");
        finish_test();
    end
endmodule // channel_fault_timing_bench
